// ===== design/fmr_ctrl.sv
// Command interpreter for lane mode, software reset, write latch and status register
`timescale 1ns/100ps
`default_nettype none
module fmr_ctrl #(
   parameter int RECOVER_CYC = fmr_pkg::RESET_RECOVER_CYC,
   parameter int STATUS_WRITE_CYC = fmr_pkg::STATUS_WRITE_CYC,
   parameter int PROGRAM_CYC = fmr_pkg::PROGRAM_CYC,
   parameter int ERASE_CYC = fmr_pkg::ERASE_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] dq_in,
   output logic [3:0] dq_out,
   output logic [3:0] dq_oe,
   input wire logic wp_n,
   input wire logic enhance_active,
   output logic four_lane_cmd_mode,
   output logic otp_mode,
   output logic [7:0] flash_status,
   output logic protect_pins_on,
   output logic busy_abort
);
   import fmr_pkg::*;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   logic sclk_prev_q;
   logic wp_meta_n_q;
   logic wp_sync_n_q;
   // Clock resets to its idle low level, so release of reset shows no false edge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         s1_q <= 6'h2F;
         s2_q <= 6'h2F;
         sclk_prev_q <= 1'b0;
         wp_meta_n_q <= 1'b1;
         wp_sync_n_q <= 1'b1;
      end else begin
         s1_q <= {cs_n, sclk, dq_in};
         s2_q <= s1_q;
         sclk_prev_q <= s2_q[4];
         // Protect pin is slow but asynchronous; raw it could split hw_protect
         wp_meta_n_q <= wp_n;
         wp_sync_n_q <= wp_meta_n_q;
      end
   end
   logic cs_sn;
   logic sclk_s;
   logic [3:0] dq_s;
   assign cs_sn = s2_q[5];
   assign sclk_s = s2_q[4];
   assign dq_s = s2_q[3:0];
   logic rise;
   logic fall;
   assign rise = sclk_s & ~sclk_prev_q & ~cs_sn;
   assign fall = ~sclk_s & sclk_prev_q & ~cs_sn;
   logic cs_prev_q;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_sn;
      end
   end
   logic frame_end;
   assign frame_end = cs_sn & ~cs_prev_q;

   // ==========================================================
   // Frame shifter: opcode then one data byte
   // ==========================================================
   logic [7:0] shift_q;
   logic [7:0] opcode_q;
   logic [7:0] data_q;
   logic [4:0] bits_q;
   logic quad_q;
   logic [4:0] step;
   assign step = quad_q ? 5'd4 : 5'd1;
   logic [5:0] bits_sum;
   assign bits_sum = {1'b0, bits_q} + {1'b0, step};
   logic [7:0] shift_next;
   assign shift_next = quad_q ? {shift_q[3:0], dq_s} : {shift_q[6:0], dq_s[0]};
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shift_q <= 8'h00;
         opcode_q <= 8'h00;
         data_q <= 8'h00;
         bits_q <= 5'h00;
      end else if (cs_sn) begin
         bits_q <= 5'h00;
      end else if (rise) begin
         shift_q <= shift_next;
         // Wrap back to a byte boundary so a long status read keeps reloading
         bits_q <= bits_sum[5] ? 5'd24 : bits_sum[4:0];
         if (bits_sum == 6'd8) begin
            opcode_q <= shift_next;
         end
         if (bits_sum == 6'd16) begin
            data_q <= shift_next;
         end
      end
   end
   // Frames with exactly an opcode, or an opcode plus exactly one byte
   logic op_only;
   logic op_byte;
   assign op_only = frame_end & (bits_q == 5'd8);
   assign op_byte = frame_end & (bits_q == 5'd16);

   // ==========================================================
   // Operation timer and busy
   // ==========================================================
   logic [31:0] timer_q;
   logic busy_q;
   logic nv_write_q;
   logic abort_q;
   logic [7:0] nv_q;
   logic latch_q;
   logic armed_q;
   logic otp_q;
   logic [7:0] nv_pend_q;

   logic is_write_op;
   logic is_wipe;
   logic [3:0] levels;
   logic hw_protect;
   assign levels = nv_q[BIT_LEVEL_HI:BIT_LEVEL_LO];
   assign hw_protect = nv_q[BIT_LOCK] & ~wp_sync_n_q & ~nv_q[BIT_PIN_OFF] & ~otp_q;
   assign is_wipe = (opcode_q == OP_SMALL_WIPE) | (opcode_q == OP_HALF_WIPE)
      | (opcode_q == OP_LARGE_WIPE);
   // Address-level protection is outside this block: any non-zero level blocks it
   logic prog_ok;
   logic chip_ok;
   assign prog_ok = latch_q & ~busy_q & (levels == 4'h0) & ~(otp_q & nv_q[BIT_LOCK]);
   assign chip_ok = latch_q & ~busy_q & (levels == 4'h0);
   logic start_prog;
   logic start_wipe;
   logic start_sw;
   assign start_prog = frame_end & (bits_q > 5'd8) & prog_ok
      & ((opcode_q == OP_PAGE_PROGRAM) | ((opcode_q == OP_QUAD_PAGE) & ~quad_q));
   assign start_wipe = frame_end & (bits_q > 5'd8) & prog_ok & is_wipe
      | op_only & chip_ok & ((opcode_q == OP_CHIP_WIPE_A) | (opcode_q == OP_CHIP_WIPE_B));
   assign start_sw = (opcode_q == OP_STATUS_WRITE) & op_byte & latch_q & ~busy_q
      & ~hw_protect;
   assign is_write_op = start_prog | start_wipe | start_sw;
   logic fire;
   assign fire = op_only & (opcode_q == OP_RESET_FIRE) & armed_q;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         timer_q <= 32'h0;
         busy_q <= 1'b0;
         nv_write_q <= 1'b0;
         abort_q <= 1'b0;
      end else if (fire) begin
         // Recovery keeps busy high; longer when an operation was cut short
         busy_q <= 1'b1;
         abort_q <= busy_q;
         nv_write_q <= 1'b0;
         timer_q <= busy_q ? 32'(RECOVER_CYC) : 32'h1;
      end else if (is_write_op) begin
         busy_q <= 1'b1;
         nv_write_q <= start_sw;
         timer_q <= start_sw ? 32'(STATUS_WRITE_CYC)
            : (start_prog ? 32'(PROGRAM_CYC) : 32'(ERASE_CYC));
      end else if (busy_q) begin
         if (timer_q <= 32'h1) begin
            busy_q <= 1'b0;
            nv_write_q <= 1'b0;
            abort_q <= 1'b0;
         end else begin
            timer_q <= timer_q - 32'h1;
         end
      end
   end
   logic op_done;
   assign op_done = busy_q & (timer_q <= 32'h1) & ~abort_q & ~fire;

   // ==========================================================
   // Write latch, arm state, lane mode, status bits
   // ==========================================================
   logic any_cmd;
   assign any_cmd = frame_end & (bits_q >= 5'd8);
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         armed_q <= 1'b0;
      end else if (any_cmd) begin
         armed_q <= op_only & (opcode_q == OP_RESET_ARM);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         latch_q <= 1'b0;
      end else if (fire) begin
         latch_q <= 1'b0;
      end else if (op_done | is_write_op & ~start_sw) begin
         latch_q <= op_done ? 1'b0 : latch_q;
      end else if (op_only & (opcode_q == OP_WRITE_ARM)) begin
         latch_q <= 1'b1;
      end else if (op_only & (opcode_q == OP_WRITE_DISARM) & ~otp_q) begin
         latch_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         quad_q <= 1'b0;
      end else if (fire) begin
         quad_q <= 1'b0;
      end else if (op_only & (opcode_q == OP_ENTER_QUAD)) begin
         quad_q <= 1'b1;
      end else if (op_only & (opcode_q == OP_LEAVE_QUAD) & ~enhance_active) begin
         quad_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         otp_q <= 1'b0;
      end else if (fire) begin
         otp_q <= 1'b0;
      end else if (op_only & (opcode_q == OP_ENTER_OTP) & ~busy_q) begin
         otp_q <= 1'b1;
      end else if (op_only & (opcode_q == OP_WRITE_DISARM)) begin
         otp_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         nv_pend_q <= STATUS_RESET;
      end else if (start_sw) begin
         if (otp_q) begin
            nv_pend_q <= nv_q | 8'h80;
         end else begin
            nv_pend_q <= {data_q[7:2], 2'b00};
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         nv_q <= STATUS_RESET;
      end else if (fire) begin
         nv_q <= STATUS_RESET;
      end else if (op_done & nv_write_q & ~hw_protect) begin
         // A write in flight when protection engages is dropped; locked bits move only on a reset fire
         nv_q <= {nv_pend_q[7:2], 2'b00};
      end
   end

   // ==========================================================
   // Status read output
   // ==========================================================
   logic [7:0] status_now;
   assign status_now = {nv_q[7:2], latch_q, busy_q};
   logic reading_q;
   logic [7:0] out_sh_q;
   logic [3:0] out_oe_q;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reading_q <= 1'b0;
         out_sh_q <= 8'h00;
         out_oe_q <= 4'h0;
      end else if (cs_sn) begin
         reading_q <= 1'b0;
         out_oe_q <= 4'h0;
      end else if (fall) begin
         if ((bits_q >= 5'd8) & ((bits_q - 5'd8) % 5'(8) == 5'd0)
            & (opcode_q == OP_STATUS_READ)) begin
            reading_q <= 1'b1;
            out_sh_q <= status_now;
            out_oe_q <= quad_q ? 4'hF : 4'h2;
         end else if (reading_q) begin
            out_sh_q <= quad_q ? {out_sh_q[3:0], 4'h0} : {out_sh_q[6:0], 1'b0};
         end
      end
   end
   assign dq_out = quad_q ? out_sh_q[7:4] : {2'b00, out_sh_q[7], 1'b0};
   assign dq_oe = out_oe_q;

   assign four_lane_cmd_mode = quad_q;
   assign otp_mode = otp_q;
   assign flash_status = status_now;
   assign protect_pins_on = ~nv_q[BIT_PIN_OFF];
   assign busy_abort = abort_q;

   // ==========================================================
   // Checks
   // ==========================================================
   fire_clears_a: assert property (@(posedge core_clk) disable iff (reset)
      fire |=> (nv_q == 8'h00) && !latch_q && !quad_q)
      else $error("reset fire did not clear state");
   arm_cancel_a: assert property (@(posedge core_clk) disable iff (reset)
      any_cmd && !(op_only && opcode_q == OP_RESET_ARM) |=> !armed_q)
      else $error("armed reset survived another command");
   latch_set_a: assert property (@(posedge core_clk) disable iff (reset)
      op_only && opcode_q == OP_WRITE_ARM && !fire && !op_done |=> latch_q)
      else $error("write arm did not set latch");
   latch_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      is_write_op |-> latch_q)
      else $error("write operation started without latch");
   busy_start_a: assert property (@(posedge core_clk) disable iff (reset)
      is_write_op && !fire |=> busy_q)
      else $error("busy not raised");
   done_latch_a: assert property (@(posedge core_clk) disable iff (reset)
      op_done |=> !latch_q)
      else $error("latch not cleared at completion");
   quad_enter_a: assert property (@(posedge core_clk) disable iff (reset)
      op_only && opcode_q == OP_ENTER_QUAD && !fire |=> quad_q)
      else $error("four lane mode not entered");
   hw_lock_a: assert property (@(posedge core_clk) disable iff (reset)
      hw_protect |-> !start_sw)
      else $error("status write in hardware protection");
   chip_wipe_a: assert property (@(posedge core_clk) disable iff (reset)
      start_wipe |-> levels == 4'h0)
      else $error("wipe with protect levels set");
   hw_hold_a: assert property (@(posedge core_clk) disable iff (reset)
      hw_protect && !fire |=> nv_q[7:2] == $past(nv_q[7:2]))
      else $error("locked status bits changed");
   otp_lock_a: assert property (@(posedge core_clk) disable iff (reset)
      otp_q && nv_q[BIT_LOCK] && !fire |=> nv_q[BIT_LOCK])
      else $error("one time area lock cleared");
   quad_leave_a: assert property (@(posedge core_clk) disable iff (reset)
      op_only && opcode_q == OP_LEAVE_QUAD && !enhance_active && !fire |=> !quad_q)
      else $error("four lane mode not left");
   abort_busy_a: assert property (@(posedge core_clk) disable iff (reset)
      fire && busy_q |=> busy_q && abort_q)
      else $error("abort recovery not flagged");
   sw_frame_a: assert property (@(posedge core_clk) disable iff (reset)
      op_only && opcode_q == OP_STATUS_WRITE && !busy_q |=> !busy_q)
      else $error("status write without data byte ran");
   disarm_clear_a: assert property (@(posedge core_clk) disable iff (reset)
      op_only && opcode_q == OP_WRITE_DISARM && !otp_q && !fire |=> !latch_q)
      else $error("write disarm left latch set");
endmodule
`default_nettype wire

// ===== inc/fmr_pkg.sv
// Package: opcodes, status layout, timing constants for the flash command controller
package fmr_pkg;
   localparam logic [7:0] OP_WRITE_ARM = 8'h06;
   localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
   localparam logic [7:0] OP_LEAVE_QUAD = 8'hFF;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET_FIRE = 8'h99;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_PAGE = 8'h32;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
   localparam logic [7:0] OP_HALF_WIPE = 8'h52;
   localparam logic [7:0] OP_LARGE_WIPE = 8'hD8;
   localparam logic [7:0] OP_CHIP_WIPE_A = 8'hC7;
   localparam logic [7:0] OP_CHIP_WIPE_B = 8'h60;
   localparam logic [7:0] OP_ENTER_OTP = 8'h3A;
   localparam logic [7:0] OP_QUAD_READ = 8'hEB;
   localparam int BIT_LOCK = 7;
   localparam int BIT_PIN_OFF = 6;
   localparam int BIT_LEVEL_HI = 5;
   localparam int BIT_LEVEL_LO = 2;
   localparam int BIT_LATCH = 1;
   localparam int BIT_BUSY = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int CLK_MHZ = 250;
   localparam int RESET_RECOVER_US = 28;
   localparam int RESET_RECOVER_CYC = RESET_RECOVER_US * CLK_MHZ;
   localparam int STATUS_WRITE_CYC = 64;
   localparam int PROGRAM_CYC = 256;
   localparam int ERASE_CYC = 1024;
endpackage

// ===== sim/fmr_ctrl_tb.sv
// Self-checking bench for the flash command controller
`timescale 1ns/100ps
`default_nettype none
module fmr_ctrl_tb;
   import fmr_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic wp_n = 1'b1;
   logic enhance_active = 1'b0;
   logic cs_n, sclk, four_lane_cmd_mode, otp_mode, protect_pins_on, busy_abort;
   logic [3:0] dq_in, dq_out, dq_oe, oe;
   logic [7:0] flash_status, rd;
   int n_fail = 0;
   int n_checks = 0;
   always #2 core_clk = ~core_clk;
   // Short busy spans keep the run brief; status write outlasts one status read
   fmr_ctrl #(.RECOVER_CYC(20), .STATUS_WRITE_CYC(400), .PROGRAM_CYC(64), .ERASE_CYC(64))
      fmr_ctrl_i (.core_clk(core_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .wp_n(wp_n),
      .enhance_active(enhance_active), .four_lane_cmd_mode(four_lane_cmd_mode),
      .otp_mode(otp_mode), .flash_status(flash_status), .protect_pins_on(protect_pins_on),
      .busy_abort(busy_abort));
   fmr_host fmr_host_i (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cmd(input logic q, input logic [7:0] op);
      fmr_host_i.frame(q, op, 1'b0, 8'h00, 0, rd, oe);
   endtask
   task automatic swr(input logic [7:0] d);
      fmr_host_i.frame(1'b0, OP_STATUS_WRITE, 1'b1, d, 0, rd, oe);
   endtask
   task automatic status_read_cmd(input logic q);
      fmr_host_i.frame(q, OP_STATUS_READ, 1'b0, 8'h00, 4, rd, oe);
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 2000 && flash_status[BIT_BUSY] !== 1'b0; k++) @(negedge core_clk);
   endtask
   task automatic t_latch;
      chk("reset status", STATUS_RESET, flash_status);
      chk("pins on", 8'h01, {7'h00, protect_pins_on});
      cmd(1'b0, OP_WRITE_ARM);
      chk("latch set", 8'h02, flash_status);
      status_read_cmd(1'b0);
      chk("status read", 8'h02, rd);
      chk("single lane", 8'h02, {4'h0, oe});
      cmd(1'b0, OP_WRITE_DISARM);
      chk("latch clear", 8'h00, flash_status);
   endtask
   task automatic t_program;
      cmd(1'b0, OP_WRITE_ARM);
      fmr_host_i.frame(1'b0, OP_PAGE_PROGRAM, 1'b1, 8'h5A, 0, rd, oe);
      chk("program busy", 8'h03, flash_status);
      wait_idle();
      chk("program done", 8'h00, flash_status);
      cmd(1'b0, OP_WRITE_ARM);
      cmd(1'b0, OP_CHIP_WIPE_B);
      chk("wipe busy", 8'h03, flash_status);
      wait_idle();
      chk("wipe done", 8'h00, flash_status);
      fmr_host_i.frame(1'b0, OP_SMALL_WIPE, 1'b1, 8'h00, 0, rd, oe);
      chk("wipe no latch", 8'h00, flash_status);
   endtask
   task automatic t_status_write;
      swr(8'h3C);
      chk("write no latch", 8'h00, flash_status);
      cmd(1'b0, OP_WRITE_ARM);
      fmr_host_i.frame(1'b0, OP_STATUS_WRITE, 1'b1, 8'h3C, 1, rd, oe);
      chk("long frame", 8'h02, flash_status);
      swr(8'h3C);
      status_read_cmd(1'b0);
      chk("busy read", 8'h03, {6'h00, rd[1:0]});
      wait_idle();
      chk("written", 8'h3C, flash_status);
      cmd(1'b0, OP_WRITE_ARM);
      cmd(1'b0, OP_CHIP_WIPE_A);
      chk("wipe blocked", 8'h3E, flash_status);
      swr(8'h40);
      wait_idle();
      chk("pin off", 8'h40, flash_status);
      chk("pins on", 8'h00, {7'h00, protect_pins_on});
   endtask
   task automatic t_protect;
      cmd(1'b0, OP_WRITE_ARM);
      swr(8'h80);
      wait_idle();
      wp_n = 1'b0;
      cmd(1'b0, OP_WRITE_ARM);
      swr(8'h00);
      chk("locked", 8'h82, flash_status);
      @(negedge core_clk);
      wp_n = 1'b1;
      swr(8'h00);
      wait_idle();
      chk("unlocked", 8'h00, flash_status);
   endtask
   task automatic t_quad;
      cmd(1'b0, OP_ENTER_QUAD);
      chk("quad on", 8'h01, {7'h00, four_lane_cmd_mode});
      cmd(1'b1, OP_WRITE_ARM);
      chk("quad arm", 8'h02, flash_status);
      status_read_cmd(1'b1);
      chk("quad read", 8'h02, rd);
      chk("quad lanes", 8'h0F, {4'h0, oe});
      fmr_host_i.frame(1'b1, OP_QUAD_PAGE, 1'b1, 8'hA5, 0, rd, oe);
      chk("no quad page", 8'h02, flash_status);
      cmd(1'b1, OP_READ);
      cmd(1'b1, OP_DUAL_IO);
      chk("no plain read", 8'h03, {flash_status[7:1], four_lane_cmd_mode});
      enhance_active = 1'b1;
      cmd(1'b1, OP_LEAVE_QUAD);
      chk("enhance leave", 8'h01, {7'h00, four_lane_cmd_mode});
      enhance_active = 1'b0;
      cmd(1'b1, OP_LEAVE_QUAD);
      chk("quad off", 8'h00, {7'h00, four_lane_cmd_mode});
      cmd(1'b0, OP_LEAVE_QUAD);
      chk("leave single", 8'h02, {flash_status[7:1], four_lane_cmd_mode});
   endtask
   task automatic t_soft_reset;
      cmd(1'b0, OP_RESET_ARM);
      cmd(1'b0, OP_RESET_FIRE);
      wait_idle();
      chk("reset", STATUS_RESET, flash_status);
      chk("no abort", 8'h00, {7'h00, busy_abort});
      cmd(1'b0, OP_WRITE_ARM);
      cmd(1'b0, OP_RESET_FIRE);
      chk("fire alone", 8'h02, flash_status);
      cmd(1'b0, OP_RESET_ARM);
      status_read_cmd(1'b0);
      cmd(1'b0, OP_RESET_FIRE);
      chk("arm cancelled", 8'h02, flash_status);
      cmd(1'b0, OP_ENTER_QUAD);
      cmd(1'b1, OP_RESET_ARM);
      cmd(1'b1, OP_RESET_FIRE);
      cmd(1'b0, OP_RESET_ARM);
      cmd(1'b0, OP_RESET_FIRE);
      wait_idle();
      chk("quad reset", 8'h00, {flash_status[7:1], four_lane_cmd_mode});
      cmd(1'b0, OP_WRITE_ARM);
      swr(8'h3C);
      cmd(1'b0, OP_RESET_ARM);
      cmd(1'b0, OP_RESET_FIRE);
      chk("abort flag", 8'h03, {6'h00, busy_abort, flash_status[BIT_BUSY]});
      wait_idle();
      chk("busy reset", STATUS_RESET, flash_status);
   endtask
   task automatic t_otp;
      cmd(1'b0, OP_ENTER_OTP);
      chk("otp on", 8'h01, {7'h00, otp_mode});
      cmd(1'b0, OP_WRITE_ARM);
      swr(8'h00);
      wait_idle();
      chk("otp lock", 8'h80, flash_status);
      cmd(1'b0, OP_WRITE_DISARM);
      chk("otp off", 8'h00, {7'h00, otp_mode});
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      reset = 1'b0;
      repeat (4) @(negedge core_clk);
      t_latch();
      t_program();
      t_status_write();
      t_protect();
      t_quad();
      t_soft_reset();
      t_otp();
      give_verdict();
   end
   // Whole sequence needs some 7000 cycles; this cuts a hang short
   initial begin
      repeat (50000) @(negedge core_clk);
      n_fail++;
      give_verdict();
   end
endmodule
`default_nettype wire

// ===== sim/fmr_host.sv
// Host serial controller model that frames commands into the flash block
`timescale 1ns/100ps
`default_nettype none
module fmr_host (
   input wire logic core_clk,
   output logic cs_n,
   output logic sclk,
   output logic [3:0] dq_in,
   input wire logic [3:0] dq_out,
   input wire logic [3:0] dq_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      dq_in = 4'hF;
   end
   task automatic half;
      repeat (4) @(negedge core_clk);
   endtask
   // Released lines toggle so no stale value can pass for data
   task automatic drift(input logic q);
      dq_in = q ? ~dq_in : {3'b111, ~dq_in[0]};
   endtask
   // Opcode, optional data byte, then n_rd bytes back; rd keeps the last byte
   task automatic frame(input logic q, input logic [7:0] op, input logic wr,
      input logic [7:0] data, input int n_rd, output logic [7:0] rd, output logic [3:0] oe);
      logic [15:0] sh;
      int per;
      int n_in;
      per = q ? 4 : 1;
      n_in = (wr ? 16 : 8) / per;
      sh = {op, data};
      rd = 8'h00;
      oe = 4'h0;
      @(negedge core_clk);
      cs_n = 1'b0;
      for (int u = 0; u < n_in + 8 * n_rd / per; u++) begin
         if (u < n_in) begin
            dq_in = q ? sh[15:12] : {3'b111, sh[15]};
            sh = sh << per;
         end else begin
            drift(q);
         end
         half();
         sclk = 1'b1;
         half();
         if (u >= n_in) begin
            rd = q ? {rd[3:0], dq_out} : {rd[6:0], dq_out[1]};
            oe = dq_oe;
         end
         sclk = 1'b0;
      end
      half();
      cs_n = 1'b1;
      drift(q);
      repeat (12) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire
